/* logic/ddrb_pkg.sv */
// constants and types shared by the burst sram interface
package ddrb_pkg;
  localparam int DW           = 18;   // data word width
  localparam int AW           = 20;   // word address width
  localparam int LANE_W       = 9;    // bits governed by one byte select
  localparam int LANES        = 2;    // byte selects per word
  localparam int FIFO_DEPTH   = 4;    // posted write entries
  localparam int CLK_MHZ      = 250;  // i_clk rate, two phases per K period
  localparam int T_CLK_NS     = 4;    // i_clk period
  localparam int K_MHZ        = CLK_MHZ / 2;
  localparam int DLL_MIN_MHZ  = 120;
  localparam int DLL_LOCK_K   = 1024; // stable K periods before lock
  localparam int T_STOP_NS    = 30;   // clock stall that resets the dll
  // least time, rounded up to whole i_clk cycles
  localparam int STOP_CYC     = (T_STOP_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int LOCK_W       = 11;
  localparam int STOP_W       = 4;
  localparam int STRAP_CYC    = 3;    // edges after reset release
  localparam int ENT_W        = AW + 2 * DW + 2 * LANES;
  // read launch stage (in i_clk cycles after the command cycle)
  localparam int LAT_DLL_ON   = 2;    // first word visible after 1.5 K
  localparam int LAT_DLL_OFF  = 1;    // first word visible after 1 K

  typedef enum logic [2:0] {
    WR_IDLE  = 3'b001,
    WR_WORD1 = 3'b010,
    WR_WORD2 = 3'b100
  } ddrb_wr_e;
endpackage : ddrb_pkg

/* logic/ddrb_sram.sv */
// burst-of-two ddr sram core: command decode, posted writes, read pipe
// Summary of operation
// R1: dll enabled: first read word appears one and a half K periods later
// R2: dll disabled: first read word appears one K period after the command
// R3: commands sampled only at the positive K rise; byte selects on both K phases
// R4: write words taken on both K phases; read words from output flops
// R5: read command latches read address and bursts two 18-bit words
// R6: second burst word uses the address with its lsb toggled
// R7: first word after next K rise, second word on the next edge
// R8: reads run to completion; a read may start every K period
// R9: outputs float once the last pending burst word has been shown
// R10: write command latches the write address register
// R11: word one at next K rise, word two at K-bar; 36 bits committed
// R12: writes accepted every K period; idle inputs ignored otherwise
// R13: byte selects sampled per word; unselected lanes keep old data
// R14: both output clocks high at power on selects single clock mode
// R15: controller inserts a nop between read and following write
// R16: write held in registers while reads occupy the array
// R17: read of just-written address returns pending write data
// R18: controller drives one load strobe shared by both banks
// R19: two free-running echo clocks follow the output clocks
// R20: in single clock mode echo clocks follow the input clocks
// R21: dll declared locked after 1024 stable K periods
// R22: K stalled for 30 ns or more resets the dll lock
// R23: dll serves K from 120 MHz up to the rated maximum
// R24: powers up deselected with data outputs floating
// R25: select 0 governs bits 8..0, select 1 governs bits 17..9
`timescale 1ns/10ps
`default_nettype none

module ddrb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic      [W-1:0] o_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [PW:0]   cnt_q;
  logic          push;
  logic          pop;

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least two");
    end
  endgenerate

  assign o_ready = (cnt_q != (PW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem_q[rptr_q];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wptr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : ddrb_fifo

module ddrb_sram #(
  parameter int ADDR_W = ddrb_pkg::AW,
  parameter int DEPTH  = ddrb_pkg::FIFO_DEPTH
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  input  wire logic                      i_kpos_phase,
  input  wire logic                      i_load_strobe_n,
  input  wire logic                      i_rw,
  input  wire logic [ADDR_W-1:0]         i_addr,
  input  wire logic [ddrb_pkg::DW-1:0]   i_d,
  input  wire logic [ddrb_pkg::LANES-1:0] i_byte_write_select_n,
  input  wire logic                      i_dll_disable_n,
  input  wire logic                      i_cpos,
  input  wire logic                      i_cneg,
  output logic      [ddrb_pkg::DW-1:0]   o_dq,
  output logic                           o_dq_oe,
  output logic                           o_echo_clock,
  output logic                           o_echo_clock_n,
  output logic                           o_dll_locked,
  output logic                           o_single_clock_mode,
  output logic                           o_wr_ready
);
  import ddrb_pkg::*;

  localparam int BW = ADDR_W - 1;
  localparam int ENT = ADDR_W + 2 * DW + 2 * LANES;

  generate
    if (K_MHZ < DLL_MIN_MHZ || ADDR_W < 2) begin : g_bad_cfg
      $error("K rate below dll range or address too narrow");
    end
  endgenerate

  // lane merge: selected lanes (active low) take new data
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
                                          input logic [DW-1:0] new_w,
                                          input logic [LANES-1:0] sel_n);
    logic [DW-1:0] r;
    r = old_w;
    for (int l = 0; l < LANES; l++) begin
      if (!sel_n[l]) begin
        r[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W]; // R25
      end
    end
    return r;
  endfunction : merge

  // two banks, one per burst word parity
  logic [DW-1:0]     bank0 [2**BW];
  logic [DW-1:0]     bank1 [2**BW];

  logic [2:0]        sync1_q;
  logic [2:0]        sync2_q;
  logic [1:0]        strap_cnt_q;
  logic              single_q;
  logic              cmd_rd;
  logic              cmd_wr;
  ddrb_wr_e          wr_st_q;
  logic              wr_next_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [ADDR_W-1:0] eaddr_q;
  logic [DW-1:0]     w0_q;
  logic [LANES-1:0]  m0_q;
  logic              push;
  logic [ENT-1:0]    push_ent;
  logic              head_vld;
  logic              drain;
  logic [ENT-1:0]    head;
  logic [ADDR_W-1:0] raddr_q;
  logic [2:0]        rv_q;
  logic [DW-1:0]     rd_b0;
  logic [DW-1:0]     rd_b1;
  logic [DW-1:0]     rd_w0;
  logic [DW-1:0]     rd_w1;
  logic [DW-1:0]     a0_q;
  logic [DW-1:0]     a1_q;
  logic              dll_on;
  logic              ld_first;
  logic              ld_second;
  logic              kprev_q;
  logic [STOP_W-1:0] stop_cnt_q;
  logic [LOCK_W-1:0] lock_cnt_q;

  // level pins from outside: dll control and output clock straps
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {i_cneg, i_cpos, i_dll_disable_n};
      sync2_q <= sync1_q;
    end
  end

  assign dll_on = sync2_q[0];

  // strap caught once after reset release, then frozen
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_cnt_q <= 2'h0;
      single_q    <= 1'b0;
    end else if (strap_cnt_q != 2'(STRAP_CYC)) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'(STRAP_CYC - 1)) begin
        single_q <= sync2_q[1] & sync2_q[2]; // R14
      end
    end
  end

  assign o_single_clock_mode = single_q;

  // command decode at the positive K rise only
  assign cmd_rd = i_kpos_phase & ~i_load_strobe_n & i_rw;  // R3 R5 R8
  assign cmd_wr = i_kpos_phase & ~i_load_strobe_n & ~i_rw; // R3 R10 R12

  // write data sequencer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_st_q   <= WR_IDLE;
      wr_next_q <= 1'b0;
      waddr_q   <= '0;
      eaddr_q   <= '0;
      w0_q      <= '0;
      m0_q      <= '1;
    end else begin
      if (cmd_wr) begin
        waddr_q <= i_addr; // R10
      end
      case (wr_st_q)
        WR_IDLE: begin
          if (cmd_wr) begin
            wr_st_q <= WR_WORD1;
          end
        end
        WR_WORD1: begin
          if (i_kpos_phase) begin
            eaddr_q   <= waddr_q;
            w0_q      <= i_d;                    // R4 R11
            m0_q      <= i_byte_write_select_n;  // R13
            wr_next_q <= cmd_wr;                 // R12
            wr_st_q   <= WR_WORD2;
          end
        end
        WR_WORD2: begin
          wr_st_q <= wr_next_q ? WR_WORD1 : WR_IDLE; // R12
        end
        default: begin
          wr_st_q <= WR_IDLE;
        end
      endcase
    end
  end

  // second word at K-bar completes the 60-bit entry: address, 36 data bits, selects
  assign push     = (wr_st_q == WR_WORD2);                // R11
  assign push_ent = {eaddr_q, w0_q, i_d, m0_q, i_byte_write_select_n};

  // posted writes wait here while reads own the array
  ddrb_fifo #(
    .W     (ENT),
    .DEPTH (DEPTH)
  ) u_wq (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_valid (push),
    .o_ready (o_wr_ready),
    .i_data  (push_ent),
    .o_valid (head_vld),
    .i_ready (~rv_q[0]),
    .o_data  (head)
  );

  assign drain = head_vld & ~rv_q[0]; // R16

  // commit head entry: word 0 to its address, word 1 to lsb toggled
  always_ff @(posedge i_clk) begin
    if (drain) begin
      if (head[ENT-1-BW]) begin
        bank1[head[ENT-1 -: BW]] <= merge(bank1[head[ENT-1 -: BW]],
          head[2*LANES+DW +: DW], head[LANES +: LANES]); // R6 R13
        bank0[head[ENT-1 -: BW]] <= merge(bank0[head[ENT-1 -: BW]],
          head[2*LANES +: DW], head[0 +: LANES]);
      end else begin
        bank0[head[ENT-1 -: BW]] <= merge(bank0[head[ENT-1 -: BW]],
          head[2*LANES+DW +: DW], head[LANES +: LANES]);
        bank1[head[ENT-1 -: BW]] <= merge(bank1[head[ENT-1 -: BW]],
          head[2*LANES +: DW], head[0 +: LANES]);
      end
    end
  end

  // read address and launch pipeline
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      raddr_q <= '0;
      rv_q    <= 3'h0;
    end else begin
      if (cmd_rd) begin
        raddr_q <= i_addr; // R5
      end
      rv_q <= {rv_q[1:0], cmd_rd}; // R8
    end
  end

  // array read with bypass: older head, then the entry being pushed
  always_comb begin
    rd_b0 = bank0[raddr_q[ADDR_W-1:1]];
    rd_b1 = bank1[raddr_q[ADDR_W-1:1]];
    if (head_vld && head[ENT-1 -: BW] == raddr_q[ADDR_W-1:1]) begin
      if (head[ENT-1-BW]) begin
        rd_b1 = merge(rd_b1, head[2*LANES+DW +: DW], head[LANES +: LANES]);
        rd_b0 = merge(rd_b0, head[2*LANES +: DW], head[0 +: LANES]);
      end else begin
        rd_b0 = merge(rd_b0, head[2*LANES+DW +: DW], head[LANES +: LANES]);
        rd_b1 = merge(rd_b1, head[2*LANES +: DW], head[0 +: LANES]);
      end
    end
    if (push && eaddr_q[ADDR_W-1:1] == raddr_q[ADDR_W-1:1]) begin // R17
      if (eaddr_q[0]) begin
        rd_b1 = merge(rd_b1, w0_q, m0_q);
        rd_b0 = merge(rd_b0, i_d, i_byte_write_select_n);
      end else begin
        rd_b0 = merge(rd_b0, w0_q, m0_q);
        rd_b1 = merge(rd_b1, i_d, i_byte_write_select_n);
      end
    end
    rd_w0 = raddr_q[0] ? rd_b1 : rd_b0; // R6
    rd_w1 = raddr_q[0] ? rd_b0 : rd_b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a0_q <= '0;
      a1_q <= '0;
    end else if (rv_q[0]) begin
      a0_q <= rd_w0;
      a1_q <= rd_w1;
    end
  end

  // launch slots depend on the latency mode
  assign ld_first  = dll_on ? rv_q[LAT_DLL_ON-1]  : rv_q[LAT_DLL_OFF-1];
  assign ld_second = dll_on ? rv_q[LAT_DLL_ON]    : rv_q[LAT_DLL_OFF];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dq    <= '0;
      o_dq_oe <= 1'b0; // R24
    end else begin
      o_dq_oe <= ld_first | ld_second; // R9
      if (ld_first) begin
        o_dq <= dll_on ? a0_q : rd_w0; // R1 R2 R4 R7
      end else if (ld_second) begin
        o_dq <= a1_q; // R7
      end
    end
  end

  // echo clocks: from the output clock pins, or K in single clock mode
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_echo_clock   <= 1'b0;
      o_echo_clock_n <= 1'b1;
    end else if (single_q) begin
      o_echo_clock   <= i_kpos_phase;  // R20
      o_echo_clock_n <= ~i_kpos_phase;
    end else begin
      o_echo_clock   <= sync2_q[1];    // R19
      o_echo_clock_n <= sync2_q[2];
    end
  end

  // a K phase that stops alternating means the clock stalled
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      kprev_q    <= 1'b0;
      stop_cnt_q <= '0;
    end else begin
      kprev_q <= i_kpos_phase;
      if (i_kpos_phase != kprev_q) begin
        stop_cnt_q <= '0;
      end else if (stop_cnt_q != STOP_W'(STOP_CYC)) begin
        stop_cnt_q <= stop_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_cnt_q <= '0;
    end else if (!dll_on || stop_cnt_q == STOP_W'(STOP_CYC)) begin
      lock_cnt_q <= '0; // R22
    end else if (i_kpos_phase && lock_cnt_q != LOCK_W'(DLL_LOCK_K)) begin
      lock_cnt_q <= lock_cnt_q + 1'b1; // R21 R23
    end
  end

  assign o_dll_locked = (lock_cnt_q == LOCK_W'(DLL_LOCK_K));
endmodule : ddrb_sram

`default_nettype wire

/* verif/ddrb_sram_sva.sv */
// assertion checker for the burst sram interface
`timescale 1ns/10ps
`default_nettype none
module ddrb_sram_sva #(
  parameter int ADDR_W = ddrb_pkg::AW,
  parameter int DEPTH  = ddrb_pkg::FIFO_DEPTH
) (
  input wire logic                       i_clk,
  input wire logic                       i_rst_b,
  input wire logic                       i_kpos_phase,
  input wire logic                       i_load_strobe_n,
  input wire logic                       i_rw,
  input wire logic [ADDR_W-1:0]          i_addr,
  input wire logic [ddrb_pkg::DW-1:0]    i_d,
  input wire logic [ddrb_pkg::LANES-1:0] i_byte_write_select_n,
  input wire logic                       i_dll_disable_n,
  input wire logic                       i_cpos,
  input wire logic                       i_cneg,
  input wire logic [ddrb_pkg::DW-1:0]    o_dq,
  input wire logic                       o_dq_oe,
  input wire logic                       o_echo_clock,
  input wire logic                       o_echo_clock_n,
  input wire logic                       o_dll_locked,
  input wire logic                       o_single_clock_mode,
  input wire logic                       o_wr_ready
);
  import ddrb_pkg::*;
  logic        rd_cmd;
  logic        ph_q;
  logic [11:0] run_q;
  logic [3:0]  hold_q;
  assign rd_cmd = i_kpos_phase && !i_load_strobe_n && i_rw;
  // alternating k cycles seen with the dll on, and k stall length
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph_q   <= 1'b0;
      run_q  <= 12'h000;
      hold_q <= 4'h0;
    end else begin
      ph_q <= i_kpos_phase;
      if (!i_dll_disable_n || ph_q == i_kpos_phase) run_q <= 12'h000;
      else if (run_q != 12'hFFF) run_q <= run_q + 12'h001;
      if (ph_q != i_kpos_phase) hold_q <= 4'h0;
      else if (hold_q != 4'hF) hold_q <= hold_q + 4'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  AST_LAT_ON: assert property (
    rd_cmd && i_dll_disable_n && $past(i_dll_disable_n, 3) &&
    $past(i_rst_b, 3) |-> ##3 o_dq_oe ##1 o_dq_oe)
    else $error("read burst late with dll on");
  AST_LAT_OFF: assert property (
    rd_cmd && !i_dll_disable_n && !$past(i_dll_disable_n, 3)
    |-> ##2 o_dq_oe ##1 o_dq_oe)
    else $error("read burst late with dll off");
  AST_BURST_TWO: assert property ($rose(o_dq_oe) |=> o_dq_oe)
    else $error("burst shorter than two words");
  AST_FLOAT: assert property ((!rd_cmd) [*5] |-> !o_dq_oe)
    else $error("outputs driven with no read pending");
  AST_RESET: assert property (disable iff (1'b0)
    !i_rst_b |-> !o_dq_oe && !o_dll_locked)
    else $error("outputs active in reset");
  AST_LOCK_EARLY: assert property ($rose(o_dll_locked)
    |-> run_q >= 12'h7F8)
    else $error("dll locked too early");
  AST_LOCK_LATE: assert property (run_q == 12'h816 |-> o_dll_locked)
    else $error("dll not locked in time");
  AST_OFF_UNLOCK: assert property (
    (!i_dll_disable_n) [*4] |-> !o_dll_locked)
    else $error("locked while dll disabled");
  AST_STALL: assert property (hold_q == 4'hA |-> !o_dll_locked)
    else $error("lock kept through clock stall");
  AST_ECHO: assert property (
    (!o_single_clock_mode && $stable(i_cpos)) [*4]
    |-> o_echo_clock == i_cpos)
    else $error("echo clock not following output clock");
  AST_ECHO_SGL: assert property (
    o_single_clock_mode && $past(o_single_clock_mode, 2)
    |-> o_echo_clock != $past(o_echo_clock) &&
        o_echo_clock != o_echo_clock_n)
    else $error("echo clock not following k in single mode");
endmodule : ddrb_sram_sva
bind ddrb_sram ddrb_sram_sva #(.ADDR_W(ADDR_W), .DEPTH(DEPTH)) u_sva (
  .i_clk, .i_rst_b, .i_kpos_phase, .i_load_strobe_n, .i_rw, .i_addr,
  .i_d, .i_byte_write_select_n, .i_dll_disable_n, .i_cpos, .i_cneg,
  .o_dq, .o_dq_oe, .o_echo_clock, .o_echo_clock_n, .o_dll_locked,
  .o_single_clock_mode, .o_wr_ready);
`default_nettype wire

/* verif/ddrb_ctrl_model.sv */
// controller model: k phase, commands and write data
`timescale 1ns/10ps
`default_nettype none
module ddrb_ctrl_model (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_b,
  output logic                         o_kpos_phase,
  output logic                         o_load_strobe_n,
  output logic                         o_rw,
  output logic [ddrb_pkg::AW-1:0]      o_addr,
  output logic [ddrb_pkg::DW-1:0]      o_d,
  output logic [ddrb_pkg::LANES-1:0]   o_byte_write_select_n
);
  import ddrb_pkg::*;
  logic hold;
  logic last_rd;
  int   pend;
  initial begin
    {o_kpos_phase, o_rw, hold, last_rd} = 4'h0;
    o_load_strobe_n       = 1'b1;
    o_addr                = '0;
    o_d                   = '0;
    o_byte_write_select_n = 2'h3;
    pend                  = 0;
  end
  always @(negedge i_clk) begin
    if (!i_rst_b) o_kpos_phase <= 1'b0;
    else if (!hold) o_kpos_phase <= ~o_kpos_phase;
  end
  // one strobe for both banks; a nop k period between read and write
  task automatic cmd(input logic rd, input logic [AW-1:0] a);
    @(posedge i_clk iff !o_kpos_phase);
    if (!rd && last_rd) repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    o_load_strobe_n <= 1'b0;
    o_rw            <= rd;
    o_addr          <= a;
    last_rd          = rd;
    @(negedge i_clk);
    o_load_strobe_n <= 1'b1;
    o_rw            <= ~rd;
    o_addr          <= ~a;
  endtask : cmd
  // read strobe placed in a k-bar cycle, which the device must ignore
  task automatic stray(input logic [AW-1:0] a);
    @(posedge i_clk iff o_kpos_phase);
    @(negedge i_clk);
    o_load_strobe_n <= 1'b0;
    o_rw            <= 1'b1;
    o_addr          <= a;
    @(negedge i_clk);
    o_load_strobe_n <= 1'b1;
  endtask : stray
  task automatic wdat(input logic [DW-1:0] w0, w1,
                      input logic [LANES-1:0] m0, m1);
    pend++;
    @(negedge i_clk);
    o_d                   <= w0;
    o_byte_write_select_n <= m0;
    @(negedge i_clk);
    o_d                   <= w1;
    o_byte_write_select_n <= m1;
    @(negedge i_clk);
    if (pend == 1) begin
      o_d                   <= ~w1;
      o_byte_write_select_n <= 2'h3;
    end
    pend--;
  endtask : wdat
endmodule : ddrb_ctrl_model
`default_nettype wire

/* verif/ddr_burst2_sram_interface_bench.sv */
// self-checking bench for the burst sram interface
`timescale 1ns/10ps
`default_nettype none
module ddr_burst2_sram_interface_bench;
  import ddrb_pkg::*;
  logic             clk;
  logic             rst_b;
  logic             dll_n;
  logic             cpos;
  logic             cneg;
  logic             kp;
  logic             ld_n;
  logic             rw;
  logic [AW-1:0]    addr;
  logic [DW-1:0]    d;
  logic [LANES-1:0] bws_n;
  logic [DW-1:0]    dq;
  logic             dq_oe;
  logic             echo;
  logic             echo_n;
  logic             locked;
  logic             single;
  logic             wr_ready;
  logic [DW-1:0]    mem [logic [AW-1:0]];
  int               num_errors = 0;
  int               total_checks = 0;
  int               cyc = 0;
  int               lat = 2;

  ddrb_ctrl_model ctl (.i_clk(clk), .i_rst_b(rst_b), .o_kpos_phase(kp),
    .o_load_strobe_n(ld_n), .o_rw(rw), .o_addr(addr), .o_d(d),
    .o_byte_write_select_n(bws_n));
  ddrb_sram dut (.i_clk(clk), .i_rst_b(rst_b), .i_kpos_phase(kp),
    .i_load_strobe_n(ld_n), .i_rw(rw), .i_addr(addr), .i_d(d),
    .i_byte_write_select_n(bws_n), .i_dll_disable_n(dll_n),
    .i_cpos(cpos), .i_cneg(cneg), .o_dq(dq), .o_dq_oe(dq_oe),
    .o_echo_clock(echo), .o_echo_clock_n(echo_n), .o_dll_locked(locked),
    .o_single_clock_mode(single), .o_wr_ready(wr_ready));

  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [DW-1:0] mrg(input logic [DW-1:0] o, n,
                                        input logic [1:0] m);
    mrg = o;
    if (!m[0]) mrg[8:0] = n[8:0];
    if (!m[1]) mrg[17:9] = n[17:9];
  endfunction : mrg
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] w0, w1,
                    input logic [1:0] m0, m1);
    if (!mem.exists(a)) mem[a] = '0;
    if (!mem.exists(a ^ 20'h0001)) mem[a ^ 20'h0001] = '0;
    mem[a]            = mrg(mem[a], w0, m0);
    mem[a ^ 20'h0001] = mrg(mem[a ^ 20'h0001], w1, m1);
    ctl.cmd(1'b0, a);
    fork
      ctl.wdat(w0, w1, m0, m1);
    join_none
  endtask : wr
  task automatic chkrd(input logic [DW-1:0] e0, e1);
    repeat (lat) @(negedge clk);
    chk({dq_oe, dq}, {1'b1, e0});
    @(negedge clk);
    chk({dq_oe, dq}, {1'b1, e1});
  endtask : chkrd
  task automatic rd(input logic [AW-1:0] a);
    logic [DW-1:0] e0;
    logic [DW-1:0] e1;
    e0 = mem[a];
    e1 = mem[a ^ 20'h0001];
    ctl.cmd(1'b1, a);
    fork
      chkrd(e0, e1);
    join_none
  endtask : rd

  task automatic t_burst();
    wr(20'h00010, 18'h2AAAA, 18'h15555, 2'h0, 2'h0);
    wr(20'h00013, 18'h3C0F0, 18'h00F0F, 2'h0, 2'h0);
    rd(20'h00010);
    rd(20'h00013);
    rd(20'h00011);
    repeat (8) @(negedge clk);
    ctl.stray(20'h00010);
    repeat (2) @(negedge clk);
    chk(dq_oe, 1'b0);
  endtask : t_burst
  task automatic t_mask();
    wr(20'h00010, 18'h3FFFF, 18'h00000, 2'h1, 2'h2);
    wr(20'h00013, 18'h12345, 18'h0ABCD, 2'h3, 2'h0);
    rd(20'h00010);
    rd(20'h00012);
    repeat (8) @(negedge clk);
  endtask : t_mask
  task automatic t_bypass();
    wr(20'h00020, 18'h11111, 18'h22222, 2'h0, 2'h0);
    rd(20'h00020);
    wr(20'h00021, 18'h3FE00, 18'h001FF, 2'h2, 2'h1);
    rd(20'h00021);
    repeat (8) @(negedge clk);
    chk(dq_oe, 1'b0);
  endtask : t_bypass
  task automatic t_echo();
    cpos <= 1'b1;
    cneg <= 1'b0;
    repeat (5) @(negedge clk);
    chk({echo, echo_n}, 2'h2);
    cpos <= 1'b0;
    cneg <= 1'b1;
    repeat (5) @(negedge clk);
    chk({echo, echo_n}, 2'h1);
  endtask : t_echo
  task automatic t_lock();
    repeat (2200) @(negedge clk);
    chk(locked, 1'b1);
    ctl.hold <= 1'b1;
    repeat (12) @(negedge clk);
    chk(locked, 1'b0);
    ctl.hold <= 1'b0;
  endtask : t_lock
  task automatic t_dll_off();
    dll_n <= 1'b0;
    lat    = 1;
    repeat (4) @(negedge clk);
    chk(locked, 1'b0);
    wr(20'h00030, 18'h0F0F0, 18'h30303, 2'h0, 2'h0);
    rd(20'h00030);
    rd(20'h00031);
    repeat (8) @(negedge clk);
  endtask : t_dll_off
  task automatic t_single();
    logic e;
    rst_b <= 1'b0;
    cpos  <= 1'b1;
    cneg  <= 1'b1;
    repeat (2) @(negedge clk);
    rst_b <= 1'b1;
    repeat (6) @(negedge clk);
    chk(single, 1'b1);
    e = echo;
    @(negedge clk);
    chk({echo, echo_n}, {~e, e});
  endtask : t_single

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    {rst_b, cpos, cneg} = 3'h0;
    dll_n               = 1'b1;
    repeat (2) @(negedge clk);
    chk({dq_oe, locked, single, wr_ready}, 4'h1);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    t_burst();
    t_mask();
    t_bypass();
    t_echo();
    t_lock();
    t_dll_off();
    t_single();
    summarize();
  end
endmodule : ddr_burst2_sram_interface_bench
`default_nettype wire
